/* File: include/fws_cfg.svh */
// Constants for the flash write-status host controller.
// Assumes a 20 MHz clock and an asynchronous byte-wide flash on the far side.
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH
`define FWS_CLK_MHZ        20
`define FWS_SKIP_US        50
`define FWS_SKIP_CYC       (`FWS_SKIP_US * `FWS_CLK_MHZ)
`define FWS_BUS_PHASE      3
`define FWS_CMD_RESET      8'hF0
`define FWS_CMD_SUSPEND    8'hB0
`define FWS_CMD_RESUME     8'h30
`define FWS_BIT_POLL       7
`define FWS_BIT_TOG1       6
`define FWS_BIT_TFAIL      5
`define FWS_BIT_ETMR       3
`define FWS_BIT_TOG2       2
`define FWS_REG_CTRL       4'h0
`define FWS_REG_ADDR       4'h1
`define FWS_REG_DATA       4'h2
`define FWS_REG_STAT       4'h3
`define FWS_REG_LAST       4'h4
`define FWS_OP_WRITE       2'h0
`define FWS_OP_READ        2'h1
`define FWS_OP_POLL        2'h2
`define FWS_OP_TIMER       2'h3
`define FWS_RES_BUSY       2'h0
`define FWS_RES_DONE       2'h1
`define FWS_RES_FAIL       2'h2
`define FWS_RES_IDLE       2'h3
`endif

/* File: include/fws_pkg.sv */
// Types shared by the flash write-status host controller.
// Assumes fws_cfg.svh is on the include path.
`default_nettype none
package fws_pkg;
  typedef struct packed {
    logic        cs_n;
    logic        oe_n;
    logic        we_n;
    logic [20:0] addr;
    logic [7:0]  dout;
    logic        doe;
  } fws_pins_t;
  typedef struct packed {
    logic       go;
    logic       wr;
    logic [20:0] addr;
    logic [7:0] data;
  } fws_cyc_t;
endpackage : fws_pkg
`default_nettype wire

/* File: hdl/fws_cycle.sv */
// One asynchronous flash bus cycle, read or write, of fixed phase length.
// Assumes the flash meets its access time within one phase of the 20 MHz clock.
`default_nettype none
`include "fws_cfg.svh"
module fws_cycle
  import fws_pkg::*;
(
  input  wire logic       clk,      // System clock.
  input  wire logic       resetn,   // Asynchronous reset, active low.
  input  wire fws_cyc_t   req,      // Cycle request.
  input  wire logic [7:0] din,      // Flash data input.
  output logic            busy,     // Cycle in flight.
  output logic            done,     // Cycle finished pulse.
  output logic [7:0]      rdata,    // Captured read byte.
  output fws_pins_t       pins      // Flash pins.
);
  typedef enum logic [1:0] {FWS_IDLE, FWS_ACT, FWS_REL} fws_cst_t;
  fws_cst_t   st_r, st_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  fws_pins_t  pins_r, pins_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       done_r, done_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    pins_nxt  = pins_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    case (st_r)
      FWS_IDLE: begin
        if (req.go) begin
          pins_nxt.addr = req.addr;
          pins_nxt.dout = req.data;
          pins_nxt.doe  = req.wr;
          pins_nxt.cs_n = 1'b0;
          pins_nxt.we_n = ~req.wr;
          pins_nxt.oe_n = req.wr;
          cnt_nxt       = 2'(`FWS_BUS_PHASE);
          st_nxt        = FWS_ACT;
        end
      end
      FWS_ACT: begin
        if (cnt_r != 2'h0) begin
          cnt_nxt = cnt_r - 2'h1;
        end else begin
          // Status appears only while chip select and output strobe are low, so sample here.
          // strobed status read
          rdata_nxt     = din;
          pins_nxt.cs_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.we_n = 1'b1;
          st_nxt        = FWS_REL;
        end
      end
      FWS_REL: begin
        pins_nxt.doe = 1'b0;
        done_nxt     = 1'b1;
        st_nxt       = FWS_IDLE;
      end
      default: st_nxt = FWS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= FWS_IDLE;
      cnt_r   <= 2'h0;
      pins_r  <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h0, dout: 8'h00, doe: 1'b0};
      rdata_r <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      pins_r  <= pins_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy  = (st_r != FWS_IDLE);
  assign done  = done_r;
  assign rdata = rdata_r;
  assign pins  = pins_r;
endmodule : fws_cycle
`default_nettype wire

/* File: hdl/fws_host.sv */
// Host controller that writes flash commands and runs the status polling procedures.
// Assumes software on a plain register port and one flash device on the pins.
`default_nettype none
`include "fws_cfg.svh"
module fws_host
  import fws_pkg::*;
(
  input  wire logic        clk,          // System clock, 20 MHz.
  input  wire logic        resetn,       // Asynchronous reset, active low.
  input  wire logic [3:0]  reg_addr,     // Register address.
  input  wire logic [31:0] reg_wdata,    // Register write data.
  input  wire logic        reg_wr,       // Register write strobe.
  input  wire logic        reg_rd,       // Register read strobe.
  output logic [31:0]      reg_rdata,    // Register read data.
  output logic             flash_cs_n,   // Flash chip select.
  output logic             flash_oe_n,   // Flash output strobe.
  output logic             flash_we_n,   // Flash write strobe.
  output logic [20:0]      flash_addr,   // Flash address.
  output logic [7:0]       flash_dq_o,   // Flash data out.
  output logic             flash_dq_oe,  // Flash data drive enable.
  input  wire logic [7:0]  flash_dq_i,   // Flash data in.
  input  wire logic        ready_busy_n  // Flash ready line, pulled up.
);
  typedef enum logic [2:0] {FWS_H_IDLE, FWS_H_RD1, FWS_H_RD2, FWS_H_RECHK, FWS_H_RST, FWS_H_WAIT} fws_hst_t;

  // Returns true when the toggle bit differs between two status reads.
  function automatic logic fws_toggled(input logic [7:0] a, input logic [7:0] b);
    return a[`FWS_BIT_TOG1] != b[`FWS_BIT_TOG1];
  endfunction : fws_toggled

  // ---------------------------------------------------------------
  // Registers and sequencer
  // ---------------------------------------------------------------
  fws_hst_t    st_r, st_nxt;
  logic [20:0] addr_r, addr_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [7:0]  first_r, first_nxt;
  logic [7:0]  last_r, last_nxt;
  logic [1:0]  res_r, res_nxt;
  logic        issued_r, issued_nxt;
  logic [15:0] gap_r, gap_nxt;
  logic        gap_ok_r, gap_ok_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  fws_cyc_t    cyc;
  logic        cyc_busy;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  fws_pins_t   pins;
  logic        start;
  logic [1:0]  op;

  // A new order is taken only when neither the sequencer nor the bus cycle is in flight.
  assign start = reg_wr && (reg_addr == `FWS_REG_CTRL) && (st_r == FWS_H_IDLE) && !cyc_busy;
  assign op    = reg_wdata[1:0];

  always_comb begin
    st_nxt     = st_r;
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    first_nxt  = first_r;
    last_nxt   = last_r;
    res_nxt    = res_r;
    issued_nxt = 1'b0;
    gap_nxt    = gap_r;
    gap_ok_nxt = gap_ok_r;
    rdata_nxt  = 32'h0;
    cyc        = '{go: 1'b0, wr: 1'b0, addr: addr_r, data: data_r};
    if (reg_wr && reg_addr == `FWS_REG_ADDR) addr_nxt = reg_wdata[20:0];
    if (reg_wr && reg_addr == `FWS_REG_DATA) data_nxt = reg_wdata[7:0];
    if (gap_r != 16'h0) gap_nxt = gap_r - 16'h1;
    gap_ok_nxt = (gap_r != 16'h0);
    case (st_r)
      FWS_H_IDLE: begin
        if (start) begin
          res_nxt = `FWS_RES_BUSY;
          case (op)
            `FWS_OP_WRITE: begin
              cyc.go = 1'b1;
              cyc.wr = 1'b1;
              gap_nxt = 16'(`FWS_SKIP_CYC);
              st_nxt  = FWS_H_WAIT;
            end
            `FWS_OP_READ, `FWS_OP_TIMER: begin
              cyc.go = 1'b1;
              st_nxt = FWS_H_WAIT;
            end
            default: begin
              cyc.go = 1'b1;
              st_nxt = FWS_H_RD1;
            end
          endcase
        end
      end
      FWS_H_RD1: begin
        if (cyc_done) begin
          first_nxt = cyc_rdata;
          cyc.go    = 1'b1;
          st_nxt    = FWS_H_RD2;
        end
      end
      FWS_H_RD2: begin
        if (cyc_done) begin
          last_nxt = cyc_rdata;
          if (!fws_toggled(first_r, cyc_rdata)) begin
            res_nxt = `FWS_RES_DONE;
            st_nxt  = FWS_H_IDLE;
          end else if (cyc_rdata[`FWS_BIT_TFAIL]) begin
            first_nxt = cyc_rdata;
            cyc.go    = 1'b1;
            st_nxt    = FWS_H_RECHK;
          end else begin
            first_nxt = cyc_rdata;
            cyc.go    = 1'b1;
          end
        end
      end
      FWS_H_RECHK: begin
        if (cyc_done) begin
          last_nxt = cyc_rdata;
          if (!fws_toggled(first_r, cyc_rdata)) begin
            res_nxt = `FWS_RES_DONE;
            st_nxt  = FWS_H_IDLE;
          end else begin
            res_nxt  = `FWS_RES_FAIL;
            cyc.go   = 1'b1;
            cyc.wr   = 1'b1;
            cyc.data = `FWS_CMD_RESET;
            st_nxt   = FWS_H_RST;
          end
        end
      end
      FWS_H_RST: begin
        if (cyc_done) st_nxt = FWS_H_IDLE;
      end
      FWS_H_WAIT: begin
        if (cyc_done) begin
          last_nxt   = cyc_rdata;
          res_nxt    = `FWS_RES_DONE;
          issued_nxt = 1'b1;
          st_nxt     = FWS_H_IDLE;
        end
      end
      default: st_nxt = FWS_H_IDLE;
    endcase
    if (reg_rd) begin
      case (reg_addr)
        `FWS_REG_ADDR: rdata_nxt = {11'h0, addr_r};
        `FWS_REG_DATA: rdata_nxt = {24'h0, data_r};
        `FWS_REG_STAT: rdata_nxt = {26'h0, gap_ok_r, ready_busy_n, (st_r != FWS_H_IDLE), issued_r, res_r};
        `FWS_REG_LAST: rdata_nxt = {24'h0, last_r};
        default:       rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r     <= FWS_H_IDLE;
      addr_r   <= 21'h0;
      data_r   <= 8'h00;
      first_r  <= 8'h00;
      last_r   <= 8'h00;
      res_r    <= `FWS_RES_IDLE;
      issued_r <= 1'b0;
      gap_r    <= 16'h0;
      gap_ok_r <= 1'b0;
      rdata_r  <= 32'h0;
    end else begin
      st_r     <= st_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      first_r  <= first_nxt;
      last_r   <= last_nxt;
      res_r    <= res_nxt;
      issued_r <= issued_nxt;
      gap_r    <= gap_nxt;
      gap_ok_r <= gap_ok_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  fws_cycle u_cycle (
    .clk    (clk),
    .resetn (resetn),
    .req    (cyc),
    .din    (flash_dq_i),
    .busy   (cyc_busy),
    .done   (cyc_done),
    .rdata  (cyc_rdata),
    .pins   (pins)
  );

  assign reg_rdata   = rdata_r;
  assign flash_cs_n  = pins.cs_n;
  assign flash_oe_n  = pins.oe_n;
  assign flash_we_n  = pins.we_n;
  assign flash_addr  = pins.addr;
  assign flash_dq_o  = pins.dout;
  assign flash_dq_oe = pins.doe;
endmodule : fws_host
`default_nettype wire

/* File: test/fws_host_properties.sv */
// Concurrent checks on the host controller's register and flash pins.
// Assumes it is bound to fws_host and sees only that module's ports.
`default_nettype none
module fws_host_properties (
  input wire logic        clk,          // System clock.
  input wire logic        resetn,       // Reset, active low.
  input wire logic [3:0]  reg_addr,     // Register address.
  input wire logic [31:0] reg_wdata,    // Register write data.
  input wire logic        reg_wr,       // Register write strobe.
  input wire logic        reg_rd,       // Register read strobe.
  input wire logic [31:0] reg_rdata,    // Register read data.
  input wire logic        flash_cs_n,   // Chip select.
  input wire logic        flash_oe_n,   // Output strobe.
  input wire logic        flash_we_n,   // Write strobe.
  input wire logic [20:0] flash_addr,   // Flash address.
  input wire logic [7:0]  flash_dq_o,   // Data out.
  input wire logic        flash_dq_oe,  // Data drive enable.
  input wire logic [7:0]  flash_dq_i,   // Data in.
  input wire logic        ready_busy_n  // Ready line.
);
  // ----------------------------------------
  // Pin and register port properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_we_low4;
    (!flash_we_n) [*4] ##1 flash_we_n;
  endsequence
  sequence s_oe_low4;
    (!flash_oe_n) [*4] ##1 flash_oe_n;
  endsequence
  AST_RD_ZERO: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_WE_LEN: assert property ($fell(flash_we_n) |-> s_we_low4)
    else $error("write strobe length wrong");
  AST_OE_LEN: assert property ($fell(flash_oe_n) |-> s_oe_low4)
    else $error("output strobe length wrong");
  AST_ADDR_HOLD: assert property (!flash_cs_n && !$fell(flash_cs_n) |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  AST_DATA_HOLD: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_dq_o))
    else $error("write data moved inside a cycle");
  AST_WE_DRIVES: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write without driving data");
  AST_OE_NODRIVE: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("host drives data during read");
  AST_CS_WITH: assert property (!flash_oe_n || !flash_we_n |-> !flash_cs_n)
    else $error("strobe without chip select");
endmodule : fws_host_properties
bind fws_host fws_host_properties i_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_cs_n(flash_cs_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
  .flash_dq_i(flash_dq_i), .ready_busy_n(ready_busy_n));
`default_nettype wire

/* File: test/fws_flash_model.sv */
// Behavioural flash status model: any write other than reset starts an operation.
// Assumes write data bit 0 set asks for an operation that never finishes.
`default_nettype none
module fws_flash_model (
  input wire logic       cs_n,   // Chip select.
  input wire logic       oe_n,   // Output strobe.
  input wire logic       we_n,   // Write strobe.
  input wire logic [7:0] din,    // Host write data.
  output logic [7:0]     dq,     // Data toward host.
  output logic           rb_drv  // Pulls ready line low.
);
  // ----------------------------------------
  // Operation state
  // ----------------------------------------
  logic busy = 1'b0, fail = 1'b0, tog = 1'b0, fop = 1'b0, pd7 = 1'b0, armed = 1'b0;
  int   left = 0;
  logic [7:0] stat;
  // A rise of the write strobe counts only after a real fall, not the first rise out of reset.
  always @(negedge we_n) armed = 1'b1;
  always @(posedge we_n) begin
    if (armed) begin
      busy = (din != 8'hF0);
      fail = 1'b0;
      fop  = din[0];
      pd7  = din[7];
      left = 3;
    end
    armed = 1'b0;
  end
  always @(posedge oe_n) begin
    if (busy) begin
      tog  = ~tog;
      left = left - 1;
      fail = fop;
      if (left <= 0 && !fop) busy = 1'b0;
    end
  end
  // status or array byte, inverted when released
  assign stat   = busy ? {~pd7, tog, fail, 5'h00} : 8'h3C;
  assign dq     = (!cs_n && !oe_n) ? stat : ~stat;
  assign rb_drv = busy;
endmodule : fws_flash_model
`default_nettype wire

/* File: test/test_fws_host.sv */
// Self-checking bench for the host controller against the flash model.
// Assumes fws_cfg.svh on the include path; the ready line has a pull-up.
`default_nettype none
`include "fws_cfg.svh"
module test_fws_host;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rb_drv;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
  logic        cs_n, oe_n, we_n, dq_oe, rbn;
  logic [20:0] fa;
  logic [7:0]  dq_o, fl_dq, dq_i;
  int          n_fail = 0, tests_run = 0;
  always #25 clk = ~clk;
  assign dq_i = dq_oe ? dq_o : fl_dq;
  assign rbn  = rb_drv ? 1'b0 : 1'b1;
  fws_host i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cs_n(cs_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
    .ready_busy_n(rbn));
  fws_flash_model i_flash (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .din(dq_o), .dq(fl_dq), .rb_drv(rb_drv));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic run(input logic [1:0] op, input logic [7:0] d, output logic [31:0] st);
    wr(`FWS_REG_DATA, {24'h0, d});
    wr(`FWS_REG_CTRL, {30'h0, op});
    for (int i = 0; i < 500; i++) begin
      rd(`FWS_REG_STAT, st);
      if (st[1:0] !== `FWS_RES_BUSY && st[3] === 1'b0) break;
    end
  endtask : run
  task automatic t_idle();
    rd(`FWS_REG_STAT, s);
    chk("idle result", s[1:0], `FWS_RES_IDLE);
    chk("idle ready", s[4], 1'b1);
    rd(4'hF, s);
    chk("unmapped", s, 32'h0);
    $display("t_idle done");
  endtask : t_idle
  task automatic t_read();
    wr(`FWS_REG_ADDR, 32'h0001_2345);
    for (int k = 1; k < 4; k += 2) begin
      run(k[1:0], 8'h00, s);
      chk("read result", s[1:0], `FWS_RES_DONE);
      rd(`FWS_REG_LAST, s);
      chk("array byte", s[7:0], 8'h3C);
      chk("flash address", fa, 32'h0001_2345);
    end
    $display("t_read done");
  endtask : t_read
  task automatic t_reset_cmd();
    run(`FWS_OP_WRITE, `FWS_CMD_RESET, s);
    chk("reset write", s[1:0], `FWS_RES_DONE);
    chk("reset ready", s[4], 1'b1);
    chk("spacing window", s[5], 1'b1);
    chk("reset byte", dq_o, `FWS_CMD_RESET);
    chk("drive released", dq_oe, 1'b0);
    repeat (1000) @(posedge clk);
    rd(`FWS_REG_STAT, s);
    chk("window over", s[5], 1'b0);
    $display("t_reset_cmd done");
  endtask : t_reset_cmd
  task automatic t_poll(input logic [7:0] d, input logic [1:0] exp);
    run(`FWS_OP_WRITE, d, s);
    rd(`FWS_REG_STAT, s);
    chk("busy line", s[4], 1'b0);
    run(`FWS_OP_POLL, 8'h00, s);
    chk("poll result", s[1:0], exp);
    if (exp == `FWS_RES_FAIL) chk("failure reset byte", dq_o, `FWS_CMD_RESET);
    rd(`FWS_REG_STAT, s);
    chk("ready after", s[4], 1'b1);
    $display("t_poll done");
  endtask : t_poll
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #3000000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_idle();
    t_read();
    t_reset_cmd();
    t_poll(8'hA0, `FWS_RES_DONE);
    t_poll(8'hA1, `FWS_RES_FAIL);
    summarize();
  end
endmodule : test_fws_host
`default_nettype wire
